// [scmc_pkg.sv]
// constants, field layout and carrier types of the system clock and
// operating mode controller
// assumes a classic wishbone master with 32-bit data and byte addresses
package scmc_pkg;

  // register index; the byte address is four times the index
  localparam logic [7:0]  OSC_MODE_IDX  = 8'h95;
  localparam int          WB_ADDR_W     = 12;
  localparam logic [11:0] OSC_MODE_ADDR = {2'b00, OSC_MODE_IDX, 2'b00};

  // field positions inside osc_mode_control
  localparam int FAST_STOP_POS = 1;
  localparam int CLK_SEL_POS   = 2;
  localparam int CPU_MODE_LO   = 3;
  localparam int CPU_MODE_HI   = 4;

  localparam logic [7:0] OSC_MODE_RST = 8'h00;

  // cpu_mode_field encodings: {green_request, sleep_request}
  localparam logic [1:0] CPU_MODE_NORMAL = 2'b00;
  localparam logic [1:0] CPU_MODE_SLEEP  = 2'b01;
  localparam logic [1:0] CPU_MODE_GREEN  = 2'b10;
  localparam logic [1:0] CPU_MODE_RSVD   = 2'b11;

  // warm-up lengths in fast_rc_osc clocks, slow mode divider
  localparam int RESET_WARM_CLKS = 2048;
  localparam int WAKE_WARM_CLKS  = 32;
  localparam int SLOW_CPU_DIV    = 4;
  localparam int FAST_CPU_DIV    = 4;
  localparam int WARM_CNT_W      = 12;
  localparam int DIV_CNT_W       = 8;

  // reported operating mode
  localparam logic [1:0] OPM_NORMAL = 2'b00;
  localparam logic [1:0] OPM_SLOW   = 2'b01;
  localparam logic [1:0] OPM_GREEN  = 2'b10;
  localparam logic [1:0] OPM_SLEEP  = 2'b11;

  typedef struct packed {
    logic [1:0] cpu_mode_field;
    logic       clock_select;
    logic       fast_osc_stop;
  } scmc_ctrl_t;

  localparam scmc_ctrl_t CTRL_RST = OSC_MODE_RST[CPU_MODE_HI:FAST_STOP_POS];

  typedef struct packed {
    logic                 cyc;
    logic                 stb;
    logic                 we;
    logic [WB_ADDR_W-1:0] adr;
    logic [3:0]           sel;
    logic [31:0]          dat;
  } scmc_wb_req_t;

  typedef enum logic [2:0] {
    ST_RESET_WARM,
    ST_RUN,
    ST_SLEEP,
    ST_WAKE_WARM,
    ST_GREEN
  } scmc_state_t;

endpackage : scmc_pkg

// [scmc_sync_edge.sv]
// two-flop synchroniser with change and rising-edge detection
// assumes the input is slower than half of clk_i
`timescale 1ns/100ps
`default_nettype none
module scmc_sync_edge #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] level_o,
  output logic              rise_o,
  output logic              change_o
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic [W-1:0] last_reg;

  // only sync_reg reads meta_reg; detectors look one stage later
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
      last_reg <= '0;
    end
    else
    begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign level_o  = sync_reg;
  assign rise_o   = sync_reg[0] & ~last_reg[0];
  assign change_o = |(sync_reg ^ last_reg);

endmodule : scmc_sync_edge
`default_nettype wire

// [scmc_top.sv]
// system clock and operating mode controller with wishbone register
// assumes oscillator levels and wake pins arrive asynchronously, the
// tick timer overflow and watchdog enable come from logic on clk_i
// limitation: each oscillator is sampled on clk_i and must run below
// half its rate, or edges are lost and the warm-up stretches
//
// What this block does
// - slow mode instruction rate is slow clock/4
// - slow osc off: sleep; slow green without watchdog
// - slow osc stop follows mode bits and watchdog enable
// - slow osc also clocks the watchdog
// - register at 0x95, bits 7:5,0 zero, reset 0
// - fast osc stop bit: 0 runs, 1 stops
// - clock select 0 fast normal, 1 slow
// - mode field: normal, sleep, green, reserved
// - after reset wait 2048 fast osc clocks
// - sleep wake waits 32 fast osc clocks
// - after reset release enter normal and run
// - sleep wake enters normal mode unless a bus write in the same cycle sets another
// - normal mode keeps slow osc running, fast osc unless its stop bit is set
// - normal mode may switch to any mode
// - clearing clock select returns slow to normal
// - green from normal wakes to normal
// - wake clears sleep and green bits
// - green from slow wakes to slow
// - sleep wakes on pins, green also on tick
// - slow mode does not stop fast osc itself
`timescale 1ns/100ps
`default_nettype none
module scmc_top
  import scmc_pkg::*;
#(
  parameter int PIN_W    = 8,
  parameter int FAST_DIV = FAST_CPU_DIV
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire scmc_pkg::scmc_wb_req_t wb_req_i,
  output logic [31:0]                 wb_dat_o,
  output logic                        wb_ack_o,
  input  wire logic                   fast_osc_clk_i,
  input  wire logic                   slow_osc_clk_i,
  input  wire logic [PIN_W-1:0]       wake_pins_i,
  input  wire logic                   tick_timer_ovf_i,
  input  wire logic                   wdt_enable_i,
  output logic                        fast_osc_en_o,
  output logic                        slow_osc_en_o,
  output logic                        sys_clk_slow_o,
  output logic                        cpu_run_o,
  output logic                        cpu_tick_o,
  output logic                        wdt_tick_o,
  output logic                        warming_o,
  output logic [1:0]                  op_mode_o
);

  import scmc_pkg::*;

  localparam logic [WARM_CNT_W-1:0] RESET_WARM_LAST =
    WARM_CNT_W'(RESET_WARM_CLKS - 1);
  localparam logic [WARM_CNT_W-1:0] WAKE_WARM_LAST =
    WARM_CNT_W'(WAKE_WARM_CLKS - 1);
  localparam logic [DIV_CNT_W-1:0]  SLOW_DIV_LAST =
    DIV_CNT_W'(SLOW_CPU_DIV - 1);
  localparam logic [DIV_CNT_W-1:0]  FAST_DIV_LAST =
    DIV_CNT_W'(FAST_DIV - 1);

  // read image of the control fields, unused bits read as zero
  function automatic logic [31:0] reg_image(input scmc_ctrl_t c);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[FAST_STOP_POS]           = c.fast_osc_stop;
    v[CLK_SEL_POS]             = c.clock_select;
    v[CPU_MODE_HI:CPU_MODE_LO] = c.cpu_mode_field;
    return v;
  endfunction : reg_image

  // counter step that wraps at last
  function automatic logic [DIV_CNT_W-1:0] div_step(
    input logic [DIV_CNT_W-1:0] cnt,
    input logic [DIV_CNT_W-1:0] last
  );
    logic [DIV_CNT_W-1:0] n;
    n = (cnt >= last) ? '0 : DIV_CNT_W'(cnt + 1'b1);
    return n;
  endfunction : div_step

  scmc_state_t           state_reg;
  scmc_state_t           state_next;
  scmc_ctrl_t            ctrl_reg;
  scmc_ctrl_t            ctrl_next;
  logic [WARM_CNT_W-1:0] warm_cnt_reg;
  logic [WARM_CNT_W-1:0] warm_cnt_next;
  logic [DIV_CNT_W-1:0]  div_cnt_reg;
  logic [DIV_CNT_W-1:0]  div_cnt_next;
  logic [31:0]           wb_dat_next;
  logic                  wb_ack_next;
  logic                  fast_en_next;
  logic                  slow_en_next;
  logic                  cpu_tick_next;
  logic                  wdt_tick_next;
  logic [1:0]            op_mode_next;
  logic                  mode_slow_reg;

  // synchronised oscillator edges and pin changes; the level outputs
  // stay open because only edges and changes matter here
  logic fast_rise;
  logic slow_rise;
  logic pin_change;

  scmc_sync_edge #(
    .W (1)
  ) u_fast_sync (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .async_i  (fast_osc_clk_i),
    .level_o  (),
    .rise_o   (fast_rise),
    .change_o ()
  );

  scmc_sync_edge #(
    .W (1)
  ) u_slow_sync (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .async_i  (slow_osc_clk_i),
    .level_o  (),
    .rise_o   (slow_rise),
    .change_o ()
  );

  scmc_sync_edge #(
    .W (PIN_W)
  ) u_pin_sync (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .async_i  (wake_pins_i),
    .level_o  (),
    .rise_o   (),
    .change_o (pin_change)
  );

  // bus decode; a write lands on the edge at which the master sees ack,
  // while it still holds address and data, read data is set up before
  wire bus_req   = wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
  wire bus_done  = wb_req_i.cyc & wb_req_i.stb & wb_ack_o;
  wire reg_hit   = (wb_req_i.adr == OSC_MODE_ADDR);
  wire reg_write = bus_done & wb_req_i.we & reg_hit & wb_req_i.sel[0];
  wire reg_read  = bus_req & ~wb_req_i.we & reg_hit;

  // requested mode and gating terms
  // mode 11 stays in the register but starts nothing
  wire req_sleep = (ctrl_reg.cpu_mode_field == CPU_MODE_SLEEP);
  wire req_green = (ctrl_reg.cpu_mode_field == CPU_MODE_GREEN);
  wire in_run    = (state_reg == ST_RUN);
  wire in_green  = (state_reg == ST_GREEN);
  wire in_sleep  = (state_reg == ST_SLEEP);
  wire in_warm   = (state_reg == ST_RESET_WARM) ||
                   (state_reg == ST_WAKE_WARM);
  // the tick timer has no clock in sleep, so only pins end it
  wire sleep_wake = in_sleep & pin_change;
  wire green_wake = in_green & (pin_change | tick_timer_ovf_i);
  // warm-up counts synchronised fast edges, not clk_i cycles
  wire warm_done  = fast_rise &
                    (((state_reg == ST_RESET_WARM) &&
                      (warm_cnt_reg == RESET_WARM_LAST)) ||
                     ((state_reg == ST_WAKE_WARM) &&
                      (warm_cnt_reg == WAKE_WARM_LAST)));

  // fast osc follows its stop bit and sleep, never the clock select; it is
  // forced on while warming so the warm-up count has edges to see
  wire fast_gate  = ~in_sleep &
                    (in_warm | ~ctrl_reg.fast_osc_stop);
  // slow osc has no stop bit of its own, the mode and watchdog enable decide
  wire slow_gate  = ~in_sleep &
                    ~(in_green & ctrl_reg.clock_select &
                      ~wdt_enable_i);

  // control register: a bus write in the same cycle as a wake clear
  // keeps the written value, so a fresh request is never lost
  always_comb
  begin
    ctrl_next = ctrl_reg;
    if (sleep_wake)
    begin
      ctrl_next.cpu_mode_field = CPU_MODE_NORMAL;
      ctrl_next.clock_select   = 1'b0;
      ctrl_next.fast_osc_stop  = 1'b0;
    end
    if (green_wake)
    begin
      ctrl_next.cpu_mode_field = CPU_MODE_NORMAL;
    end
    if (reg_write)
    begin
      ctrl_next = wb_req_i.dat[CPU_MODE_HI:FAST_STOP_POS];
    end
  end

  // mode sequencing
  always_comb
  begin
    state_next    = state_reg;
    warm_cnt_next = warm_cnt_reg;
    case (state_reg)
      ST_RESET_WARM, ST_WAKE_WARM:
      begin
        if (warm_done)
        begin
          state_next    = ST_RUN;
          warm_cnt_next = '0;
        end
        else if (fast_rise)
        begin
          warm_cnt_next = WARM_CNT_W'(warm_cnt_reg + 1'b1);
        end
      end
      ST_RUN:
      begin
        if (req_sleep)
        begin
          state_next = ST_SLEEP;
        end
        else if (req_green)
        begin
          state_next = ST_GREEN;
        end
      end
      ST_SLEEP:
      begin
        if (sleep_wake)
        begin
          state_next    = ST_WAKE_WARM;
          warm_cnt_next = '0;
        end
      end
      ST_GREEN:
      begin
        if (green_wake)
        begin
          state_next = ST_RUN;
        end
      end
      // an unknown state restarts the warm-up rather than run blind
      default:
      begin
        state_next    = ST_RESET_WARM;
        warm_cnt_next = '0;
      end
    endcase
  end

  // instruction cycle divider
  // it restarts on a clock switch, so no tick after it comes short
  wire use_slow  = ctrl_reg.clock_select;
  wire src_edge  = use_slow ? slow_rise : (fast_rise & fast_osc_en_o);
  wire [DIV_CNT_W-1:0] div_last = use_slow ? SLOW_DIV_LAST : FAST_DIV_LAST;
  wire div_hit   = in_run & src_edge & (div_cnt_reg >= div_last);

  always_comb
  begin
    div_cnt_next = div_cnt_reg;
    if (!in_run || (use_slow != mode_slow_reg))
    begin
      div_cnt_next = '0;
    end
    else if (src_edge)
    begin
      div_cnt_next = div_step(div_cnt_reg, div_last);
    end
  end

  assign cpu_tick_next = div_hit & (use_slow == mode_slow_reg);
  assign wdt_tick_next = slow_rise & slow_osc_en_o;
  assign fast_en_next  = fast_gate;
  assign slow_en_next  = slow_gate;
  // sleep and green report first, whatever the clock select holds
  assign op_mode_next  = in_sleep ? OPM_SLEEP :
                         in_green ? OPM_GREEN :
                         use_slow ? OPM_SLOW  : OPM_NORMAL;

  // wishbone answer: one wait state, unmapped reads return zero; ack is
  // registered, so back-to-back requests always see one idle cycle
  assign wb_ack_next = bus_req;
  assign wb_dat_next = reg_read ? reg_image(ctrl_reg) : 32'h0000_0000;

  // mode_slow_reg holds last cycle's clock select, so a switch shows as
  // a one-cycle mismatch that clears the divider
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg    <= ST_RESET_WARM;
      ctrl_reg     <= CTRL_RST;
      warm_cnt_reg <= '0;
      div_cnt_reg  <= '0;
      mode_slow_reg <= 1'b0;
    end
    else
    begin
      state_reg    <= state_next;
      ctrl_reg     <= ctrl_next;
      warm_cnt_reg <= warm_cnt_next;
      div_cnt_reg  <= div_cnt_next;
      mode_slow_reg <= use_slow;
    end
  end

  // every mode, run and oscillator enable output is registered from the same cycle's state_reg and ctrl_reg, the slow enable also from wdt_enable_i,
  // so a state or control change moves the mode, run and oscillator enables together on the same edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o       <= 1'b0;
      wb_dat_o       <= 32'h0000_0000;
      fast_osc_en_o  <= 1'b1;
      slow_osc_en_o  <= 1'b1;
      sys_clk_slow_o <= 1'b0;
      cpu_run_o      <= 1'b0;
      cpu_tick_o     <= 1'b0;
      wdt_tick_o     <= 1'b0;
      warming_o      <= 1'b1;
      op_mode_o      <= OPM_NORMAL;
    end
    else
    begin
      wb_ack_o       <= wb_ack_next;
      wb_dat_o       <= wb_dat_next;
      fast_osc_en_o  <= fast_en_next;
      slow_osc_en_o  <= slow_en_next;
      sys_clk_slow_o <= use_slow;
      cpu_run_o      <= in_run;
      cpu_tick_o     <= cpu_tick_next;
      wdt_tick_o     <= wdt_tick_next;
      warming_o      <= in_warm;
      op_mode_o      <= op_mode_next;
    end
  end

endmodule : scmc_top
`default_nettype wire

// [scmc_monitor.sv]
// port assertions for the clock and operating mode controller
// assumes the single clk_i domain, bound onto scmc_top
`timescale 1ns/100ps
`default_nettype none
module scmc_monitor
  import scmc_pkg::*;
(
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  input wire scmc_pkg::scmc_wb_req_t wb_req_i,
  input wire logic [31:0]            wb_dat_o,
  input wire logic                   wb_ack_o,
  input wire logic                   fast_osc_en_o,
  input wire logic                   slow_osc_en_o,
  input wire logic                   sys_clk_slow_o,
  input wire logic                   cpu_run_o,
  input wire logic                   cpu_tick_o,
  input wire logic                   warming_o,
  input wire logic [1:0]             op_mode_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire req_new = wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;

  a_ack_answer: assert property (req_new |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single pulse after request");
  a_read_pad: assert property (
    wb_ack_o |-> wb_dat_o[31:5] == '0 && !wb_dat_o[0])
    else $error("unused register bits read nonzero");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == '0)
    else $error("read data outside ack");
  a_sleep_osc_off: assert property (
    op_mode_o == OPM_SLEEP |-> !fast_osc_en_o && !slow_osc_en_o)
    else $error("oscillator enabled in sleep");
  a_halt_idle: assert property (op_mode_o[1] |-> !cpu_run_o)
    else $error("cpu runs in green or sleep");
  a_warm_halt: assert property (warming_o |-> !cpu_run_o)
    else $error("cpu runs during warm-up");
  a_tick_in_run: assert property (cpu_tick_o |-> cpu_run_o)
    else $error("instruction tick while halted");
  a_run_slow_on: assert property (cpu_run_o |-> slow_osc_en_o)
    else $error("slow oscillator stopped while running");
  a_green_normal: assert property (
    op_mode_o == OPM_GREEN && !sys_clk_slow_o |-> slow_osc_en_o)
    else $error("slow oscillator stopped in normal green");
  a_sel_mode: assert property (
    cpu_run_o && $stable(sys_clk_slow_o) |->
    (op_mode_o == OPM_SLOW) == sys_clk_slow_o)
    else $error("reported mode differs from clock select");

  c_sleep: cover property (op_mode_o == OPM_SLEEP);
  c_green: cover property (op_mode_o == OPM_GREEN);
  c_slow:  cover property (op_mode_o == OPM_SLOW);
endmodule : scmc_monitor

bind scmc_top scmc_monitor mon (
  .clk_i          (clk_i),
  .rst_i          (rst_i),
  .wb_req_i       (wb_req_i),
  .wb_dat_o       (wb_dat_o),
  .wb_ack_o       (wb_ack_o),
  .fast_osc_en_o  (fast_osc_en_o),
  .slow_osc_en_o  (slow_osc_en_o),
  .sys_clk_slow_o (sys_clk_slow_o),
  .cpu_run_o      (cpu_run_o),
  .cpu_tick_o     (cpu_tick_o),
  .warming_o      (warming_o),
  .op_mode_o      (op_mode_o)
);
`default_nettype wire

// [test_system_clock_mode_control.sv]
// self-checking bench for the clock and operating mode controller
// assumes oscillators modelled from clk_i, gated by the enables
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, a) \
  begin \
    total_checks++; \
    if ((a) !== (e)) \
    begin \
      num_errors++; \
      $display("mismatch %s exp %0h got %0h", nm, e, a); \
    end \
  end
module test_system_clock_mode_control;
  import scmc_pkg::*;
  logic         clk_i = 1'b0;
  logic         rst_i = 1'b1;
  scmc_wb_req_t req = '0;
  logic [31:0]  wb_dat_o;
  logic         wb_ack_o;
  logic         fast_c = 1'b0;
  logic         slow_c = 1'b0;
  logic [7:0]   pins = 8'h00;
  logic         tick = 1'b0;
  logic         wdt = 1'b0;
  logic         fast_osc_en_o, slow_osc_en_o, sys_clk_slow_o;
  logic         cpu_run_o, cpu_tick_o, wdt_tick_o, warming_o;
  logic [1:0]   op_mode_o;
  logic [2:0]   ph = 3'h0;
  int           cycles = 0;
  int           t0, n;
  int           num_errors = 0;
  int           total_checks = 0;

  scmc_top #(.PIN_W(8), .FAST_DIV(4)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .fast_osc_clk_i(fast_c), .slow_osc_clk_i(slow_c),
    .wake_pins_i(pins), .tick_timer_ovf_i(tick), .wdt_enable_i(wdt),
    .fast_osc_en_o(fast_osc_en_o), .slow_osc_en_o(slow_osc_en_o),
    .sys_clk_slow_o(sys_clk_slow_o), .cpu_run_o(cpu_run_o),
    .cpu_tick_o(cpu_tick_o), .wdt_tick_o(wdt_tick_o),
    .warming_o(warming_o), .op_mode_o(op_mode_o)
  );

  always #20 clk_i = ~clk_i;

  // a stopped oscillator holds still, like the real one
  always @(posedge clk_i)
  begin
    ph <= ph + 3'h1;
    cycles <= cycles + 1;
    if (ph[0] && fast_osc_en_o)
      fast_c <= ~fast_c;
    if (ph == 3'h7 && slow_osc_en_o)
      slow_c <= ~slow_c;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  task automatic wb(input logic we, input logic [11:0] a,
                    input logic [7:0] d, output logic [31:0] q);
    int k;
    req <= '{1'b1, 1'b1, we, a, 4'h1, {24'h0, d}};
    k = 0;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && k < 20)
    begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 20)
    begin
      num_errors++;
      $display("mismatch ack exp 1 got 0");
    end
    q = wb_dat_o;
    req <= '0;
    @(posedge clk_i);
  endtask : wb

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    logic [31:0] q;
    wb(1'b0, a, 8'h00, q);
    `CHK("register", {24'h0, e}, q)
  endtask : rd

  task automatic wait_n(input int k);
    repeat (k) @(posedge clk_i);
  endtask : wait_n

  task automatic wait_run(output int w);
    int k;
    k = 0;
    while (cpu_run_o !== 1'b1 && k < 20000)
    begin
      @(posedge clk_i);
      k++;
    end
    w = cycles - t0;
  endtask : wait_run

  task automatic count(input int len, input bit sel_wdt, output int c);
    c = 0;
    repeat (len)
    begin
      @(posedge clk_i);
      c += sel_wdt ? int'(wdt_tick_o) : int'(cpu_tick_o);
    end
  endtask : count

  task automatic set_mode(input logic [7:0] d, input logic [1:0] e);
    wr(OSC_MODE_ADDR, d);
    wait_n(3);
    `CHK("mode", e, op_mode_o)
  endtask : set_mode

  task automatic pulse_tick;
    tick <= 1'b1;
    @(posedge clk_i);
    tick <= 1'b0;
    wait_n(4);
  endtask : pulse_tick

  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t0 = cycles;
    @(posedge clk_i);
    `CHK("warming", 1'b1, warming_o)
    rd(OSC_MODE_ADDR, 8'h00);
    wr(OSC_MODE_ADDR, 8'he7);
    `CHK("slow on", 1'b1, slow_osc_en_o)
    rd(OSC_MODE_ADDR, 8'h06);
    wr(12'h250, 8'h1e);
    rd(12'h250, 8'h00);
    wr(OSC_MODE_ADDR, 8'h00);
    wait_run(n);
    `CHK("reset warm", 1'b1, n inside {[8180:8210]})
    `CHK("mode", OPM_NORMAL, op_mode_o)
    `CHK("oscs", 2'b11, {fast_osc_en_o, slow_osc_en_o})
    count(160, 1'b0, n);
    `CHK("fast ticks", 1'b1, n inside {[9:11]})
    count(160, 1'b1, n);
    `CHK("wdt ticks", 1'b1, n inside {[9:11]})
    set_mode(8'h18, OPM_NORMAL);
    $display("test reset and normal done");
    set_mode(8'h04, OPM_SLOW);
    `CHK("slow select", 1'b1, sys_clk_slow_o)
    `CHK("fast kept", 1'b1, fast_osc_en_o)
    count(640, 1'b0, n);
    `CHK("slow ticks", 1'b1, n inside {[9:11]})
    set_mode(8'h06, OPM_SLOW);
    `CHK("fast stop", 2'b01, {fast_osc_en_o, slow_osc_en_o})
    $display("test slow done");
    set_mode(8'h16, OPM_GREEN);
    `CHK("green osc", 3'b000, {fast_osc_en_o, slow_osc_en_o, cpu_run_o})
    pulse_tick();
    `CHK("mode", OPM_SLOW, op_mode_o)
    rd(OSC_MODE_ADDR, 8'h06);
    wdt <= 1'b1;
    set_mode(8'h16, OPM_GREEN);
    `CHK("wdt osc", 1'b1, slow_osc_en_o)
    pins <= ~pins;
    wait_n(6);
    `CHK("pin wake", OPM_SLOW, op_mode_o)
    set_mode(8'h00, OPM_NORMAL);
    set_mode(8'h10, OPM_GREEN);
    `CHK("green osc", 2'b11, {fast_osc_en_o, slow_osc_en_o})
    pulse_tick();
    `CHK("mode", OPM_NORMAL, op_mode_o)
    $display("test green done");
    set_mode(8'h0e, OPM_SLEEP);
    `CHK("sleep osc", 2'b00, {fast_osc_en_o, slow_osc_en_o})
    pulse_tick();
    `CHK("tick ignored", OPM_SLEEP, op_mode_o)
    t0 = cycles;
    pins <= ~pins;
    @(posedge clk_i);
    wait_run(n);
    `CHK("wake warm", 1'b1, n inside {[120:150]})
    `CHK("mode", OPM_NORMAL, op_mode_o)
    rd(OSC_MODE_ADDR, 8'h00);
    $display("test sleep done");
    end_sim();
  end

  initial
  begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    end_sim();
  end
endmodule : test_system_clock_mode_control
`default_nettype wire
